/* rtl/tau_top.sv */
// Table pointer, table latch, holding registers and the unlock sequence.
// Assumes one core clock, a Wishbone classic master, and a flash array
// that answers reads and long operations with one-cycle strobes.
`timescale 1ns/1ns
`include "tau_map.svh"
module tau_top (
  // Clock, reset and enable.
  input wire logic clock,
  input wire logic rstn,
  input wire logic ce,
  // Wishbone classic slave.
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Core table instruction port.
  input wire logic table_go,
  input wire logic table_is_write,
  input wire tau_pkg::tau_mode_t table_mode,
  input wire logic seq_break,
  output logic core_stall,
  // Flash byte read path.
  output logic mem_rd_req,
  output logic [21:0] mem_rd_addr,
  input wire logic mem_rd_valid,
  input wire logic [15:0] mem_rd_word,
  // Flash long operations.
  output logic nv_erase,
  output logic nv_program,
  output logic [14:0] nv_block_addr,
  output logic [1:0] nv_region,
  input wire logic nv_done,
  input wire logic [`TAU_HOLD_IDX_W-1:0] hold_rd_idx,
  output logic [7:0] hold_rd_data
);
  import tau_pkg::*;

  logic [21:0] ptr_q;
  logic [7:0] latch_q;
  logic [31:0] wb_dat_q;
  logic ack_q;
  tau_key_t key_q;
  tau_op_t op_q;
  logic stall_q;
  logic rd_req_q;
  logic [21:0] rd_addr_q;
  logic erase_q;
  logic prog_q;
  logic prog_kind_q;
  logic [14:0] blk_q;
  logic wen_q;
  logic free_q;
  logic done_q;
  logic [1:0] region_q;
  logic accept;
  logic acc_rd;
  logic acc_wr;
  logic [21:0] pre_ptr;
  logic [21:0] eff_ptr;
  logic [21:0] post_ptr;
  logic bus_req;
  logic bus_wr;
  logic wr_key;
  logic wr_ctrl;
  logic start_ok;
  logic rd_done;
  logic nv_end;
  logic [7:0] rd_byte;

  // Steps only the low 21 bits so the space select bit never moves.
  function automatic logic [21:0] tau_step(input logic [21:0] p,
                                           input logic dn);
    logic [20:0] low;
    low = dn ? p[20:0] - 21'h000001 : p[20:0] + 21'h000001;
    tau_step = {p[21], low};
  endfunction

  assign accept = ce && table_go && op_q == TAU_OP_IDLE;
  assign acc_rd = accept && !table_is_write;
  assign acc_wr = accept && table_is_write;
  assign pre_ptr = tau_step(ptr_q, 1'b0);
  assign eff_ptr = table_mode == TAU_PRE_INC ? pre_ptr : ptr_q;
  assign rd_done = ce && op_q == TAU_OP_READ && mem_rd_valid;
  assign nv_end = ce && op_q == TAU_OP_NV && nv_done;
  assign rd_byte = rd_addr_q[0] ? mem_rd_word[15:8] : mem_rd_word[7:0];

  always_comb begin
    case (table_mode)
      TAU_KEEP: post_ptr = ptr_q;
      TAU_POST_INC: post_ptr = pre_ptr;
      TAU_POST_DEC: post_ptr = tau_step(ptr_q, 1'b1);
      TAU_PRE_INC: post_ptr = pre_ptr;
      default: post_ptr = ptr_q;
    endcase
  end

  assign bus_req = ce && wb_cyc_i && wb_stb_i && !ack_q;
  assign bus_wr = bus_req && wb_we_i && wb_sel_i[0];
  assign wr_key = bus_wr && wb_adr_i == `TAU_OFS_KEY;
  assign wr_ctrl = bus_wr && wb_adr_i == `TAU_OFS_CTRL;
  // Start needs the write enable and both keys in order.
  assign start_ok = wr_ctrl && wb_dat_i[`TAU_CTRL_START] &&
    wb_dat_i[`TAU_CTRL_WEN] && key_q == TAU_KEY_GOT2 &&
    op_q == TAU_OP_IDLE && !accept && !seq_break;

  // Bus answers one cycle after the request; unmapped offsets read zero.
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      ack_q <= 1'b0;
      wb_dat_q <= 32'h00000000;
    end else if (ce) begin
      ack_q <= bus_req;
      if (bus_req) begin
        case (wb_adr_i)
          `TAU_OFS_PTR_LOW: wb_dat_q <= {24'h000000, ptr_q[7:0]};
          `TAU_OFS_PTR_HIGH: wb_dat_q <= {24'h000000, ptr_q[15:8]};
          `TAU_OFS_PTR_UPPER: wb_dat_q <= {26'h0000000, ptr_q[21:16]};
          `TAU_OFS_LATCH: wb_dat_q <= {24'h000000, latch_q};
          `TAU_OFS_CTRL: wb_dat_q <= {24'h000000, region_q, done_q, free_q,
                                      1'b0, wen_q, 1'b0,
                                      op_q == TAU_OP_NV};
          default: wb_dat_q <= 32'h00000000;
        endcase
      end
    end
  end

  // Table accesses win over a bus write to the pointer in the same cycle.
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      ptr_q <= `TAU_PTR_RST;
    end else if (ce) begin
      if (accept) begin
        ptr_q <= post_ptr;
      end else if (bus_wr) begin
        case (wb_adr_i)
          `TAU_OFS_PTR_LOW: ptr_q[7:0] <= wb_dat_i[7:0];
          `TAU_OFS_PTR_HIGH: ptr_q[15:8] <= wb_dat_i[7:0];
          `TAU_OFS_PTR_UPPER: ptr_q[21:16] <= wb_dat_i[5:0];
          default: ptr_q <= ptr_q;
        endcase
      end
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      latch_q <= `TAU_LATCH_RST;
    end else if (ce) begin
      if (rd_done) begin
        latch_q <= rd_byte;
      end else if (bus_wr && wb_adr_i == `TAU_OFS_LATCH) begin
        latch_q <= wb_dat_i[7:0];
      end
    end
  end

  // Control bits; done is sticky and its set beats a software clear.
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      wen_q <= 1'b0;
      free_q <= 1'b0;
      region_q <= `TAU_REGION_RST;
      done_q <= 1'b0;
    end else if (ce) begin
      if (wr_ctrl) begin
        wen_q <= wb_dat_i[`TAU_CTRL_WEN];
        free_q <= wb_dat_i[`TAU_CTRL_FREE];
        region_q <= wb_dat_i[`TAU_CTRL_REGION_LO +: 2];
      end
      if (nv_end) begin
        done_q <= 1'b1;
      end else if (wr_ctrl && !wb_dat_i[`TAU_CTRL_DONE]) begin
        done_q <= 1'b0;
      end
    end
  end

  // Progress is lost on any other bus write with byte lane 0 enabled, a table access or a break.
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      key_q <= TAU_KEY_IDLE;
    end else if (ce) begin
      if (seq_break) begin
        key_q <= TAU_KEY_IDLE;
      end else if (wr_key && wb_dat_i[7:0] == `TAU_KEY_FIRST) begin
        key_q <= TAU_KEY_GOT1;
      end else if (wr_key && wb_dat_i[7:0] == `TAU_KEY_SECOND &&
                   key_q == TAU_KEY_GOT1) begin
        key_q <= TAU_KEY_GOT2;
      end else if (bus_wr || accept) begin
        key_q <= TAU_KEY_IDLE;
      end
    end
  end

  // Operation sequencing; the core is held while a read or long op runs.
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      op_q <= TAU_OP_IDLE;
      stall_q <= 1'b0;
      rd_req_q <= 1'b0;
      rd_addr_q <= `TAU_PTR_RST;
      erase_q <= 1'b0;
      prog_q <= 1'b0;
      prog_kind_q <= 1'b0;
      blk_q <= 15'h0000;
    end else if (ce) begin
      erase_q <= 1'b0;
      prog_q <= 1'b0;
      case (op_q)
        TAU_OP_IDLE: begin
          if (acc_rd) begin
            op_q <= TAU_OP_READ;
            stall_q <= 1'b1;
            rd_req_q <= 1'b1;
            rd_addr_q <= eff_ptr;
          end else if (start_ok) begin
            op_q <= TAU_OP_NV;
            stall_q <= 1'b1;
            erase_q <= wb_dat_i[`TAU_CTRL_FREE];
            prog_q <= !wb_dat_i[`TAU_CTRL_FREE];
            prog_kind_q <= !wb_dat_i[`TAU_CTRL_FREE];
            blk_q <= ptr_q[21:7];
          end
        end
        TAU_OP_READ: begin
          if (mem_rd_valid) begin
            op_q <= TAU_OP_IDLE;
            stall_q <= 1'b0;
            rd_req_q <= 1'b0;
          end
        end
        TAU_OP_NV: begin
          if (nv_done) begin
            op_q <= TAU_OP_IDLE;
            stall_q <= 1'b0;
          end
        end
        default: begin
          op_q <= TAU_OP_IDLE;
          stall_q <= 1'b0;
          rd_req_q <= 1'b0;
        end
      endcase
    end
  end

  // Only the low seven bits matter for a table write; flash is untouched.
  tau_hold_bank u_hold (
    .clock(clock),
    .rstn(rstn),
    .ce(ce),
    .we(acc_wr),
    .wr_idx(eff_ptr[`TAU_HOLD_IDX_W-1:0]),
    .wr_data(latch_q),
    .clr(nv_end && prog_kind_q),
    .rd_idx(hold_rd_idx),
    .rd_data_q(hold_rd_data)
  );

  assign wb_dat_o = wb_dat_q;
  assign wb_ack_o = ack_q;
  assign core_stall = stall_q;
  assign mem_rd_req = rd_req_q;
  assign mem_rd_addr = rd_addr_q;
  assign nv_erase = erase_q;
  assign nv_program = prog_q;
  assign nv_block_addr = blk_q;
  assign nv_region = region_q;

  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rstn);

  sequence s_key2;
    key_q == TAU_KEY_GOT2;
  endsequence
  sequence s_start;
    ce && wr_ctrl && wb_dat_i[`TAU_CTRL_START] && wb_dat_i[`TAU_CTRL_WEN] &&
    op_q == TAU_OP_IDLE && !accept && !seq_break;
  endsequence

  top_bit_a: assert property (accept |=> ptr_q[21] == $past(ptr_q[21]))
    else $error("pointer bit 21 changed on a table access");
  pre_addr_a: assert property (acc_rd && table_mode == TAU_PRE_INC |=>
    rd_addr_q[20:0] == $past(ptr_q[20:0]) + 21'h000001)
    else $error("pre-increment read used the old address");
  dec_step_a: assert property (accept && table_mode == TAU_POST_DEC |=>
    ptr_q[20:0] == $past(ptr_q[20:0]) - 21'h000001)
    else $error("post-decrement did not step the pointer down");
  byte_pick_a: assert property (rd_done |=> latch_q == ($past(rd_addr_q[0]) ?
    $past(mem_rd_word[15:8]) : $past(mem_rd_word[7:0])))
    else $error("wrong byte of the word reached the latch");
  read_stall_a: assert property (acc_rd |=> core_stall && mem_rd_req)
    else $error("core not held during a table read");
  read_free_a: assert property (rd_done |=> !core_stall [*2])
    else $error("core still held after read data arrived");
  unlock_gate_a: assert property ($rose(nv_erase || nv_program) |->
    $past(key_q) == TAU_KEY_GOT2)
    else $error("long operation started without unlock");
  key_order_a: assert property (ce && wr_key && wb_dat_i[7:0] ==
    `TAU_KEY_SECOND && key_q == TAU_KEY_IDLE && !seq_break |=>
    key_q == TAU_KEY_IDLE)
    else $error("second key accepted before first key");
  long_stall_a: assert property (s_key2 ##0 s_start |=>
    (nv_erase || nv_program) && core_stall)
    else $error("valid start did not launch and stall");
  break_a: assert property (ce && seq_break |=> key_q == TAU_KEY_IDLE &&
    !nv_erase && !nv_program)
    else $error("disturbed sequence kept its progress");
  drop_a: assert property (ce && bus_wr && !wr_key && !seq_break |=>
    key_q == TAU_KEY_IDLE)
    else $error("unrelated write kept unlock progress");
  ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("bus acknowledge held for two cycles");
endmodule

/* rtl/tau_map.svh */
// Offsets, field positions, reset values and key constants for the table
// access and unlock block. Assumes a byte-addressed Wishbone slave port.
`ifndef TAU_MAP_SVH
`define TAU_MAP_SVH
`define TAU_OFS_PTR_LOW 8'h00
`define TAU_OFS_PTR_HIGH 8'h04
`define TAU_OFS_PTR_UPPER 8'h08
`define TAU_OFS_LATCH 8'h0C
`define TAU_OFS_CTRL 8'h10
`define TAU_OFS_KEY 8'h14
`define TAU_KEY_FIRST 8'h55
`define TAU_KEY_SECOND 8'hAA
`define TAU_CTRL_START 0
`define TAU_CTRL_WEN 2
`define TAU_CTRL_FREE 4
`define TAU_CTRL_DONE 5
`define TAU_CTRL_REGION_LO 6
`define TAU_PTR_RST 22'h000000
`define TAU_LATCH_RST 8'h00
`define TAU_REGION_RST 2'h0
`define TAU_HOLD_RST 8'hFF
`define TAU_HOLD_DEPTH 128
`define TAU_HOLD_IDX_W 7
`endif

/* rtl/tau_pkg.sv */
// Types shared by the table access and unlock block.
// Assumes the map header supplies all numeric constants.
package tau_pkg;
  typedef enum logic [1:0] {
    TAU_KEEP = 2'h0,
    TAU_POST_INC = 2'h1,
    TAU_POST_DEC = 2'h2,
    TAU_PRE_INC = 2'h3
  } tau_mode_t;
  typedef enum logic [1:0] {
    TAU_KEY_IDLE = 2'h0,
    TAU_KEY_GOT1 = 2'h1,
    TAU_KEY_GOT2 = 2'h3
  } tau_key_t;
  typedef enum logic [1:0] {
    TAU_OP_IDLE = 2'h0,
    TAU_OP_READ = 2'h1,
    TAU_OP_NV = 2'h3
  } tau_op_t;
endpackage

/* rtl/tau_hold_bank.sv */
// Write-block holding registers, one byte each, with a flash read port.
// Assumes one clock, active-low async reset and a freezing clock enable.
`timescale 1ns/1ns
`include "tau_map.svh"
module tau_hold_bank (
  // Clock and reset.
  input wire logic clock,
  input wire logic rstn,
  input wire logic ce,
  // Byte write from the table latch.
  input wire logic we,
  input wire logic [`TAU_HOLD_IDX_W-1:0] wr_idx,
  input wire logic [7:0] wr_data,
  // Return every byte to the blank value after programming.
  input wire logic clr,
  // Read port for the flash array.
  input wire logic [`TAU_HOLD_IDX_W-1:0] rd_idx,
  output logic [7:0] rd_data_q
);
  logic [7:0] mem_q [0:`TAU_HOLD_DEPTH-1];

  // A blank byte leaves its flash location untouched when programmed.
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      for (int i = 0; i < `TAU_HOLD_DEPTH; i++) begin
        mem_q[i] <= `TAU_HOLD_RST;
      end
    end else if (ce) begin
      if (clr) begin
        for (int i = 0; i < `TAU_HOLD_DEPTH; i++) begin
          mem_q[i] <= `TAU_HOLD_RST;
        end
      end else if (we) begin
        mem_q[wr_idx] <= wr_data;
      end
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      rd_data_q <= `TAU_HOLD_RST;
    end else if (ce) begin
      rd_data_q <= mem_q[rd_idx];
    end
  end
endmodule

/* verif/tau_flash_model.sv */
// Flash array stand-in that answers byte reads and long operations.
// Assumes the strobe and level contract of the table access block.
`timescale 1ns/1ns
module tau_flash_model (
  // Clock and reset.
  input wire logic clock,
  input wire logic rstn,
  // Latency of the next answer, set by the bench.
  input wire logic [3:0] lat,
  // Byte read path.
  input wire logic mem_rd_req,
  input wire logic [21:0] mem_rd_addr,
  output logic mem_rd_valid,
  output logic [15:0] mem_rd_word,
  // Long operations.
  input wire logic nv_erase,
  input wire logic nv_program,
  output logic nv_done
);
  logic [4:0] rc_q;
  logic [4:0] oc_q;
  logic rb_q;
  logic ob_q;
  logic [7:0] lo;
  assign lo = (mem_rd_addr[8:1] + mem_rd_addr[16:9])
    ^ {mem_rd_addr[21], mem_rd_addr[20:14]};
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      rb_q <= 1'b0;
      rc_q <= 5'h00;
      mem_rd_valid <= 1'b0;
      mem_rd_word <= 16'hA5A5;
    end else begin
      mem_rd_valid <= 1'b0;
      // Toggle between answers so a stale word is never mistaken for data.
      mem_rd_word <= ~mem_rd_word;
      if (mem_rd_req && !rb_q && !mem_rd_valid) begin
        rb_q <= 1'b1;
        rc_q <= {1'b0, lat};
      end else if (rb_q && rc_q != 5'h00) begin
        rc_q <= rc_q - 5'h01;
      end else if (rb_q) begin
        rb_q <= 1'b0;
        mem_rd_valid <= 1'b1;
        mem_rd_word <= {lo ^ 8'hC3, lo};
      end
    end
  end
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      ob_q <= 1'b0;
      oc_q <= 5'h00;
      nv_done <= 1'b0;
    end else begin
      nv_done <= 1'b0;
      if ((nv_erase || nv_program) && !ob_q) begin
        ob_q <= 1'b1;
        oc_q <= {1'b0, lat} + 5'h03;
      end else if (ob_q && oc_q != 5'h00) begin
        oc_q <= oc_q - 5'h01;
      end else if (ob_q) begin
        ob_q <= 1'b0;
        nv_done <= 1'b1;
      end
    end
  end
endmodule

/* verif/testbench.sv */
// Self-checking bench for the table access and unlock block.
// Assumes the flash stand-in model and the register map header.
`timescale 1ns/1ns
`include "tau_map.svh"
module testbench;
  import tau_pkg::*;
  logic clock = 0, rstn = 0, ce = 1, cyc = 0, stb = 0, we = 0;
  logic go = 0, tw = 0, brk = 0, stall, rreq, rval, ack, ers, prg, done;
  logic [7:0] adr = 0, hdat, q8;
  logic [31:0] dw = 0, rd, q;
  logic [3:0] lat = 0, sel = 0;
  logic [6:0] hidx = 0;
  logic [21:0] raddr, p, e, np;
  logic [15:0] rword;
  logic [14:0] blk, blk_seen;
  logic [1:0] nreg, reg_seen;
  tau_mode_t md = TAU_KEEP, m;
  int mismatches = 0, comparisons = 0, cycles = 0, pc = 0, ec = 0, n;
  integer seed = 32'h8a58;
  always #5 clock = ~clock;
  tau_top dut (.clock(clock), .rstn(rstn), .ce(ce), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
    .wb_dat_i(dw), .wb_dat_o(rd), .wb_ack_o(ack), .table_go(go),
    .table_is_write(tw), .table_mode(md), .seq_break(brk),
    .core_stall(stall), .mem_rd_req(rreq), .mem_rd_addr(raddr),
    .mem_rd_valid(rval), .mem_rd_word(rword), .nv_erase(ers),
    .nv_program(prg), .nv_block_addr(blk), .nv_region(nreg),
    .nv_done(done), .hold_rd_idx(hidx), .hold_rd_data(hdat));
  tau_flash_model flash (.clock(clock), .rstn(rstn), .lat(lat),
    .mem_rd_req(rreq), .mem_rd_addr(raddr), .mem_rd_valid(rval),
    .mem_rd_word(rword), .nv_erase(ers), .nv_program(prg),
    .nv_done(done));
  task test_done;
    if (mismatches == 0 && comparisons > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  always @(posedge clock) begin
    cycles++;
    if (prg === 1'b1) begin
      pc++;
      blk_seen = blk;
    end
    if (ers === 1'b1) begin
      ec++;
      reg_seen = nreg;
    end
    if (cycles == 20000) begin
      mismatches++;
      test_done;
    end
  end
  task chk(input logic [31:0] g, input logic [31:0] x);
    comparisons++;
    if (g !== x) begin
      mismatches++;
      $display("mismatch %0t got %h expected %h", $time, g, x);
    end
  endtask
  task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    cyc <= 1;
    stb <= 1;
    we <= w;
    sel <= 4'h1;
    adr <= a;
    dw <= d;
    do begin
      @(posedge clock);
    end while (ack !== 1'b1);
    q = rd;
    cyc <= 0;
    stb <= 0;
    sel <= 4'h0;
  endtask
  task setptr(input logic [21:0] v);
    wb(1, `TAU_OFS_PTR_LOW, {24'h0, v[7:0]});
    wb(1, `TAU_OFS_PTR_HIGH, {24'h0, v[15:8]});
    wb(1, `TAU_OFS_PTR_UPPER, {26'h0, v[21:16]});
  endtask
  task chkptr(input logic [21:0] v);
    wb(0, `TAU_OFS_PTR_LOW, 0);
    chk(q, v[7:0]);
    wb(0, `TAU_OFS_PTR_HIGH, 0);
    chk(q, v[15:8]);
    wb(0, `TAU_OFS_PTR_UPPER, 0);
    chk(q, v[21:16]);
  endtask
  task tab(input logic w, input tau_mode_t k);
    @(posedge clock);
    go <= 1;
    tw <= w;
    md <= k;
    @(posedge clock);
    go <= 0;
  endtask
  task waitidle;
    while (stall !== 1'b0) begin
      @(posedge clock);
    end
  endtask
  // Pointer steps keep bit 21 and wrap inside the 21-bit program space.
  function automatic logic [21:0] step(logic [21:0] v, logic dn);
    return {v[21], dn ? v[20:0] - 21'h1 : v[20:0] + 21'h1};
  endfunction
  function automatic logic [7:0] mbyte(logic [21:0] a);
    logic [7:0] l;
    l = (a[8:1] + a[16:9]) ^ {a[21], a[20:14]};
    return a[0] ? l ^ 8'hC3 : l;
  endfunction
  task unlock(input logic [7:0] c, input int how);
    if (how != 3) wb(1, `TAU_OFS_KEY, `TAU_KEY_FIRST);
    if (how == 1) wb(1, `TAU_OFS_PTR_LOW, 0);
    wb(1, `TAU_OFS_KEY, `TAU_KEY_SECOND);
    if (how == 2) begin
      @(posedge clock);
      brk <= 1;
      @(posedge clock);
      brk <= 0;
    end
    wb(1, `TAU_OFS_CTRL, c);
    chk(stall, how == 0);
    waitidle;
  endtask
  initial begin
    repeat (8) @(posedge clock);
    rstn <= 1;
    for (int a = 0; a < 28; a += 4) begin
      wb(0, a[7:0], 0);
      chk(q, 0);
    end
    for (int i = 0; i < 16; i++) begin
      p = 22'($random(seed));
      m = tau_mode_t'(2'(i + 1));
      if (i == 0) p = 22'h3FFFFF;
      if (i == 1) p = 22'h200000;
      if (i == 2) p = 22'h1FFFFF;
      lat <= 4'($random(seed));
      e = (m == TAU_PRE_INC) ? step(p, 0) : p;
      np = (m == TAU_KEEP) ? p : step(p, m == TAU_POST_DEC);
      setptr(p);
      tab(0, m);
      @(posedge clock);
      chk({stall, rreq}, 2'b11);
      chk(raddr, e);
      waitidle;
      chk(stall, 0);
      wb(0, `TAU_OFS_LATCH, 0);
      chk(q, mbyte(e));
      chkptr(np);
    end
    for (int i = 0; i < 8; i++) begin
      p = 22'($random(seed));
      if (i == 0) p[6:0] = 7'h7F;
      m = tau_mode_t'(2'(i));
      q8 = 8'($random(seed));
      e = (m == TAU_PRE_INC) ? step(p, 0) : p;
      np = (m == TAU_KEEP) ? p : step(p, m == TAU_POST_DEC);
      wb(1, `TAU_OFS_LATCH, {24'h0, q8});
      setptr(p);
      tab(1, m);
      @(posedge clock);
      chk({stall, rreq}, 0);
      hidx <= e[6:0];
      repeat (2) @(posedge clock);
      chk(hdat, q8);
      chkptr(np);
    end
    for (int h = 1; h < 5; h++) begin
      n = pc + ec;
      unlock(h == 4 ? 8'h01 : 8'h05, h);
      chk(pc + ec, n);
    end
    p = 22'($random(seed));
    setptr(p);
    n = pc;
    unlock(8'h05, 0);
    chk(pc, n + 1);
    chk(blk_seen, p[21:7]);
    @(posedge clock);
    chk(hdat, 8'hFF);
    wb(0, `TAU_OFS_CTRL, 0);
    chk(q, 32'h24);
    n = ec;
    unlock(8'h95, 0);
    chk(ec, n + 1);
    chk(reg_seen, 2'h2);
    // A table access offered while the enable is low must be lost.
    ce <= 0;
    tab(1, TAU_POST_INC);
    @(posedge clock);
    ce <= 1;
    chkptr(p);
    test_done;
  end
endmodule
